// ---- include/analog_input_conditioning_defs.vh ----
// Purpose: Constants for the analogue input conditioning block
// Assumes: Parameter addresses are 16-bit word addresses as printed
// Notes:   Negative limits are formed in code from the positive ones
//
// Function
// - Each channel accepts -10 V to +10 V as signed millivolt samples.
// - Channel one readback is read-only signed 16-bit mV, -10000..10000.
// - Channel two readback is read-only signed 16-bit mV, -10000..10000.
// - Signed offset -5000..5000 mV, default zero, corrects channel one.
// - Unsigned dead band 0..1000 mV zeroes samples whose magnitude fits it.
// - Dead band is centred on the offset-corrected value, not raw.
// - Corrected dead-banded value feeds control modes and the readback.
// - Channel one can be the current or speed setpoint source.
// - Current scale: setpoint at +10 V, 0.01 A, +-30000, default 300.
// - Speed scale: setpoint rpm at +10 V, +-30000, default 3000.
// - Speed setpoint magnitude is clamped to the maximum speed limit.
// - A negative scale inverts setpoint polarity against the input.
// - Maximum speed limit is unsigned 16-bit rpm, at most 13200.
`ifndef ANALOG_INPUT_CONDITIONING_DEFS_VH
`define ANALOG_INPUT_CONDITIONING_DEFS_VH

// ==========================================================
// Parameter addresses
`define CHAN1_VOLTAGE_READBACK_ADDR 16'h0902
`define CHAN2_VOLTAGE_READBACK_ADDR 16'h090A
`define CHAN1_DEAD_BAND_ADDR        16'h0912
`define CHAN1_OFFSET_TRIM_ADDR      16'h0916
`define CHAN1_CURRENT_SCALE_ADDR    16'h2006
`define CHAN1_SPEED_SCALE_ADDR      16'h2106
`define MAX_SPEED_LIMIT_ADDR        16'h1204

// ==========================================================
// Reset values
`define CHAN1_DEAD_BAND_RST         16'h0000
`define CHAN1_OFFSET_TRIM_RST       16'h0000
`define CHAN1_CURRENT_SCALE_RST     16'h012C
`define CHAN1_SPEED_SCALE_RST       16'h0BB8
`define MAX_SPEED_LIMIT_RST         16'h3390

// ==========================================================
// Value limits (magnitudes)
`define INPUT_LIMIT_MV              16'h2710
`define OFFSET_LIMIT_MV             16'h1388
`define DEAD_BAND_LIMIT_MV          16'h03E8
`define SCALE_LIMIT                 16'h7530
`define MAX_SPEED_LIMIT_RPM         16'h3390
`define SETPOINT_LIMIT              16'h7FFF

// ==========================================================
// Arithmetic
`define FULL_SCALE_DIVISOR          33'h000002710

`endif

// ---- core/analog_input_conditioning.v ----
// Purpose: Offset, dead band and setpoint scaling of channel one; channel two is only limited
// Assumes: Samples arrive synchronous to clock as signed mV words
// Notes:   Parameter writes outside their range are clamped to the limit
`timescale 1ns/1ns
`include "analog_input_conditioning_defs.vh"

module analog_input_conditioning
(
   // Clock and reset
   input  wire               clock,
   input  wire               rst_n,
   // Channel one converter samples
   input  wire signed [15:0] chan1_sample,
   input  wire               chan1_valid,
   // Channel two converter samples
   input  wire signed [15:0] chan2_sample,
   input  wire               chan2_valid,
   // Operating mode select, high for speed control
   input  wire               speed_mode,
   // Parameter access port
   input  wire [15:0]        param_addr,
   input  wire               param_wr_en,
   input  wire [15:0]        param_wr_data,
   input  wire               param_rd_en,
   output reg  [15:0]        param_rd_data,
   output reg                param_rd_valid,
   output reg                param_error,
   // Conditioned channel one value
   output reg  signed [15:0] chan1_conditioned,
   output reg                chan1_cond_valid,
   // Setpoints to the control loops
   output reg  signed [15:0] current_setpoint,
   output reg                current_setpoint_valid,
   output reg  signed [15:0] speed_setpoint,
   output reg                speed_setpoint_valid
);

   // ==========================================================
   // Functions

   // Symmetric saturation of a wide signed value to +-lim
   // Serves the input limits, the trims and the setpoint caps
   function signed [15:0] clamp_sym;
      input signed [32:0] v;
      input        [15:0] lim;
      reg   signed [32:0] l;
      begin
         l = {17'h00000, lim};
         if (v > l)
            clamp_sym = lim;
         else if (v < -l)
            clamp_sym = -lim;
         else
            clamp_sym = v[15:0];
      end
   endfunction

   // Sign extension of a 16-bit word to the wide arithmetic width
   // Widest product is 10000 x 30000, well inside 33 signed bits
   function signed [32:0] sext;
      input [15:0] w;
      begin
         sext = {{17{w[15]}}, w};
      end
   endfunction

   // Unsigned upper limit of a 16-bit word
   // Used where the parameter has no negative range
   function [15:0] clamp_max;
      input [15:0] w;
      input [15:0] lim;
      begin
         if (w > lim)
            clamp_max = lim;
         else
            clamp_max = w;
      end
   endfunction

   // ==========================================================
   // Parameter registers
   // Writable values come back to their defaults on reset
   reg        [15:0] dead_band_reg;
   reg signed [15:0] offset_trim_reg;
   reg signed [15:0] current_scale_reg;
   reg signed [15:0] speed_scale_reg;
   reg        [15:0] max_speed_reg;
   reg signed [15:0] chan2_readback_reg;

   // Working values of conditioning and scaling
   // Combinational intermediates; only the outputs hold state
   reg signed [15:0] cond_next;
   reg signed [15:0] chan1_raw;
   reg signed [15:0] chan2_lim;
   reg signed [32:0] corr_wide;
   reg signed [15:0] corr;
   reg        [15:0] corr_mag;
   reg signed [32:0] cur_quot;
   reg signed [32:0] spd_quot;
   reg signed [32:0] cur_prod;
   reg signed [32:0] spd_prod;
   reg signed [15:0] cur_next;
   reg signed [15:0] spd_sat;
   reg signed [15:0] spd_next;

   // Address hit on any mapped parameter
   // Feeds only the error pulse; reads and writes decode on their own
   wire addr_hit;
   wire addr_ro;

   assign addr_hit = (param_addr == `CHAN1_VOLTAGE_READBACK_ADDR) ||
                     (param_addr == `CHAN2_VOLTAGE_READBACK_ADDR) ||
                     (param_addr == `CHAN1_DEAD_BAND_ADDR)        ||
                     (param_addr == `CHAN1_OFFSET_TRIM_ADDR)      ||
                     (param_addr == `CHAN1_CURRENT_SCALE_ADDR)    ||
                     (param_addr == `CHAN1_SPEED_SCALE_ADDR)      ||
                     (param_addr == `MAX_SPEED_LIMIT_ADDR);
   assign addr_ro  = (param_addr == `CHAN1_VOLTAGE_READBACK_ADDR) ||
                     (param_addr == `CHAN2_VOLTAGE_READBACK_ADDR);

   // ==========================================================
   // Channel one conditioning

   // Input limit, offset correction, then dead band around zero
   // The band compare is inclusive: a magnitude equal to it reads 0
   always @*
   begin
      chan1_raw = clamp_sym(sext(chan1_sample), `INPUT_LIMIT_MV);
      corr_wide = sext(chan1_raw) + sext(offset_trim_reg);
      corr      = clamp_sym(corr_wide, `INPUT_LIMIT_MV);
      if (corr[15])
         corr_mag = -corr;
      else
         corr_mag = corr;
      if (corr_mag <= dead_band_reg)
         cond_next = 16'h0000;
      else
         cond_next = corr;
   end

   // Channel two only needs its input limit
   // It has no trim or band; it shares clamp_sym with channel one
   always @*
   begin
      chan2_lim = clamp_sym(sext(chan2_sample), `INPUT_LIMIT_MV);
   end

   // Register the conditioned value for readback and the loops
   // It holds between samples so the readback stays steady
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         chan1_conditioned <= 16'h0000;
         chan1_cond_valid  <= 1'b0;
      end
      else
      begin
         chan1_cond_valid <= chan1_valid;
         if (chan1_valid)
            chan1_conditioned <= cond_next;
      end
   end

   // Hold the latest channel two sample for readback
   // Between samples the readback keeps the last limited value
   always @(posedge clock)
   begin
      if (!rst_n)
         chan2_readback_reg <= 16'h0000;
      else if (chan2_valid)
         chan2_readback_reg <= chan2_lim;
   end

   // ==========================================================
   // Setpoint scaling

   // Products of the conditioned value and each scale
   always @*
   begin
      cur_prod = sext(chan1_conditioned) * sext(current_scale_reg);
      spd_prod = sext(chan1_conditioned) * sext(speed_scale_reg);
   end

   // Linear scaling; sign of the scale carries the inversion.
   // Signed division truncates toward zero, so a result below one
   // setpoint unit reads as zero in either sign
   always @*
   begin
      cur_quot = cur_prod / $signed(`FULL_SCALE_DIVISOR);
      spd_quot = spd_prod / $signed(`FULL_SCALE_DIVISOR);
      cur_next = clamp_sym(cur_quot, `SETPOINT_LIMIT);
      spd_sat  = clamp_sym(spd_quot, `SETPOINT_LIMIT);
      spd_next = clamp_sym(sext(spd_sat), max_speed_reg);
   end

   // Deliver the setpoint of the selected operating mode
   // Both values follow every sample; only the valids obey the mode,
   // so a mode change shows from the next sample on
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         current_setpoint       <= 16'h0000;
         speed_setpoint         <= 16'h0000;
         current_setpoint_valid <= 1'b0;
         speed_setpoint_valid   <= 1'b0;
      end
      else
      begin
         current_setpoint_valid <= chan1_cond_valid && !speed_mode;
         speed_setpoint_valid   <= chan1_cond_valid && speed_mode;
         if (chan1_cond_valid)
         begin
            current_setpoint <= cur_next;
            speed_setpoint   <= spd_next;
         end
      end
   end

   // ==========================================================
   // Parameter writes

   // Writable parameters, clamped into their legal range
   // Out-of-range data is clamped, never refused
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         dead_band_reg     <= `CHAN1_DEAD_BAND_RST;
         offset_trim_reg   <= `CHAN1_OFFSET_TRIM_RST;
         current_scale_reg <= `CHAN1_CURRENT_SCALE_RST;
         speed_scale_reg   <= `CHAN1_SPEED_SCALE_RST;
         max_speed_reg     <= `MAX_SPEED_LIMIT_RST;
      end
      else if (param_wr_en)
      begin
         if (param_addr == `CHAN1_DEAD_BAND_ADDR)
            dead_band_reg <= clamp_max(param_wr_data,
                                       `DEAD_BAND_LIMIT_MV);
         else if (param_addr == `CHAN1_OFFSET_TRIM_ADDR)
            offset_trim_reg <= clamp_sym(sext(param_wr_data),
                                         `OFFSET_LIMIT_MV);
         else if (param_addr == `CHAN1_CURRENT_SCALE_ADDR)
            current_scale_reg <= clamp_sym(sext(param_wr_data),
                                           `SCALE_LIMIT);
         else if (param_addr == `CHAN1_SPEED_SCALE_ADDR)
            speed_scale_reg <= clamp_sym(sext(param_wr_data),
                                         `SCALE_LIMIT);
         else if (param_addr == `MAX_SPEED_LIMIT_ADDR)
            max_speed_reg <= clamp_max(param_wr_data,
                                       `MAX_SPEED_LIMIT_RPM);
      end
   end

   // ==========================================================
   // Parameter reads and access errors

   // Read answer one cycle after the request
   // A read in the cycle of a write to it returns the old value
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         param_rd_data  <= 16'h0000;
         param_rd_valid <= 1'b0;
      end
      else
      begin
         param_rd_valid <= param_rd_en;
         if (param_rd_en)
         begin
            if (param_addr == `CHAN1_VOLTAGE_READBACK_ADDR)
               param_rd_data <= chan1_conditioned;
            else if (param_addr == `CHAN2_VOLTAGE_READBACK_ADDR)
               param_rd_data <= chan2_readback_reg;
            else if (param_addr == `CHAN1_DEAD_BAND_ADDR)
               param_rd_data <= dead_band_reg;
            else if (param_addr == `CHAN1_OFFSET_TRIM_ADDR)
               param_rd_data <= offset_trim_reg;
            else if (param_addr == `CHAN1_CURRENT_SCALE_ADDR)
               param_rd_data <= current_scale_reg;
            else if (param_addr == `CHAN1_SPEED_SCALE_ADDR)
               param_rd_data <= speed_scale_reg;
            else if (param_addr == `MAX_SPEED_LIMIT_ADDR)
               param_rd_data <= max_speed_reg;
            else
               param_rd_data <= 16'h0000;
         end
      end
   end

   // Error pulse for unmapped access or a write to a readback
   // A refused write leaves every register as it was
   always @(posedge clock)
   begin
      if (!rst_n)
         param_error <= 1'b0;
      else
         param_error <= ((param_rd_en || param_wr_en) && !addr_hit) ||
                        (param_wr_en && addr_ro);
   end

endmodule // analog_input_conditioning

// ---- tb/sample_source.sv ----
// Purpose: Converter model feeding signed mV samples to the block
// Assumes: One strobe cycle per sample, driven just after a clock edge
// Notes:   Data lines show the inverse value once the strobe is gone
`timescale 1ns/1ns
module sample_source
(
   // Clock
   input  logic               clock,
   // Converter samples
   output logic signed [15:0] chan1_sample,
   output logic               chan1_valid,
   output logic signed [15:0] chan2_sample,
   output logic               chan2_valid
);
   // ======================================================
   // Idle state at time zero
   initial
   begin
      chan1_sample = 16'h0000;
      chan1_valid  = 1'b0;
      chan2_sample = 16'h0000;
      chan2_valid  = 1'b0;
   end

   // Channel one sample, any value within the 16-bit word
   task automatic send1(input logic [15:0] v);
      @(posedge clock);
      chan1_sample <= v;
      chan1_valid  <= 1'b1;
      @(posedge clock);
      chan1_valid  <= 1'b0;
      chan1_sample <= ~v;
   endtask

   // Channel two sample
   task automatic send2(input logic [15:0] v);
      @(posedge clock);
      chan2_sample <= v;
      chan2_valid  <= 1'b1;
      @(posedge clock);
      chan2_valid  <= 1'b0;
      chan2_sample <= ~v;
   endtask
endmodule // sample_source

// ---- tb/aic_chk.sv ----
// Purpose: Port assertions for the analogue input conditioning block
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached to the design top by bind
`timescale 1ns/1ns
module aic_chk
(
   // Clock and reset
   input logic               clock,
   input logic               rst_n,
   // Inputs
   input logic               chan1_valid,
   input logic               speed_mode,
   input logic [15:0]        param_addr,
   input logic               param_wr_en,
   input logic               param_rd_en,
   // Outputs
   input logic               param_rd_valid,
   input logic               param_error,
   input logic signed [15:0] chan1_conditioned,
   input logic               chan1_cond_valid,
   input logic               current_setpoint_valid,
   input logic signed [15:0] speed_setpoint,
   input logic               speed_setpoint_valid
);
   // ======================================================
   // Checks on the parameter port and sample path
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_read_answer: assert property (param_rd_en |=> param_rd_valid)
      else $error("read not answered");
   a_no_stray_read: assert property (!param_rd_en |=> !param_rd_valid)
      else $error("unrequested read answer");
   a_ro_refused: assert property (param_wr_en &&
      (param_addr == 16'h0902 || param_addr == 16'h090A) |=> param_error)
      else $error("readback write not refused");
   a_cond_follows: assert property (chan1_valid |=> chan1_cond_valid)
      else $error("conditioned value missing");
   a_cond_quiet: assert property (!chan1_valid |=> !chan1_cond_valid)
      else $error("conditioned valid without sample");
   a_cond_range: assert property (chan1_cond_valid |->
      chan1_conditioned >= -16'sh2710 && chan1_conditioned <= 16'sh2710)
      else $error("conditioned value out of range");
   a_speed_gate: assert property (chan1_valid ##1 speed_mode |=>
      speed_setpoint_valid && !current_setpoint_valid)
      else $error("speed setpoint not selected");
   a_current_gate: assert property (chan1_valid ##1 !speed_mode |=>
      current_setpoint_valid && !speed_setpoint_valid)
      else $error("current setpoint not selected");
   a_speed_clamp: assert property (speed_setpoint_valid |->
      speed_setpoint <= 16'sh3390 && speed_setpoint >= -16'sh3390)
      else $error("speed setpoint above limit");
   a_setpoint_cause: assert property (speed_setpoint_valid ||
      current_setpoint_valid |-> $past(chan1_valid, 2))
      else $error("setpoint without sample");
endmodule // aic_chk

bind analog_input_conditioning aic_chk chk_u
(
   .clock(clock), .rst_n(rst_n), .chan1_valid(chan1_valid),
   .speed_mode(speed_mode), .param_addr(param_addr),
   .param_wr_en(param_wr_en), .param_rd_en(param_rd_en),
   .param_rd_valid(param_rd_valid), .param_error(param_error),
   .chan1_conditioned(chan1_conditioned),
   .chan1_cond_valid(chan1_cond_valid),
   .current_setpoint_valid(current_setpoint_valid),
   .speed_setpoint(speed_setpoint),
   .speed_setpoint_valid(speed_setpoint_valid)
);

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for analogue input conditioning
// Assumes: Parameter reads answer one cycle after the strobe
// Notes:   Cases run offset, dead band, scaling and clamping
`timescale 1ns/1ns
module tb_top;
   // ======================================================
   // Signals
   logic              clock, rst_n, speed_mode, param_wr_en, param_rd_en;
   logic [15:0]       param_addr, param_wr_data;
   wire  [15:0]       param_rd_data;
   wire               param_rd_valid, param_error, chan1_valid, chan2_valid;
   wire signed [15:0] chan1_sample, chan2_sample, chan1_conditioned;
   wire signed [15:0] current_setpoint, speed_setpoint;
   wire               chan1_cond_valid, current_setpoint_valid;
   wire               speed_setpoint_valid;
   int                mismatches, check_count;
   // Offset, band, I scale, n scale, mode, sample, cond, I, n
   logic [15:0] tbl [5][9] = '{
      '{16'h0000, 16'h0000, 16'h012C, 16'h0BB8, 16'h0,
        16'h1388, 16'h1388, 16'h0096, 16'h05DC},
      '{16'hFF38, 16'h0014, 16'h012C, 16'h0BB8, 16'h1,
        16'h00D7, 16'h0000, 16'h0000, 16'h0000},
      '{16'hFF38, 16'h0014, 16'h012C, 16'h0BB8, 16'h1,
        16'h00B3, 16'hFFEB, 16'h0000, 16'hFFFA},
      '{16'h1B58, 16'h0000, 16'h8AD0, 16'h7530, 16'h0,
        16'h2328, 16'h2710, 16'h8AD0, 16'h3390},
      '{16'h1B58, 16'h0000, 16'h8AD0, 16'h7530, 16'h1,
        16'hD120, 16'hEC78, 16'h3A98, 16'hCC70}};

   // ======================================================
   // Design, converter model and clock
   analog_input_conditioning dut_u (.clock(clock), .rst_n(rst_n),
      .chan1_sample(chan1_sample), .chan1_valid(chan1_valid),
      .chan2_sample(chan2_sample), .chan2_valid(chan2_valid),
      .speed_mode(speed_mode), .param_addr(param_addr),
      .param_wr_en(param_wr_en), .param_wr_data(param_wr_data),
      .param_rd_en(param_rd_en), .param_rd_data(param_rd_data),
      .param_rd_valid(param_rd_valid), .param_error(param_error),
      .chan1_conditioned(chan1_conditioned),
      .chan1_cond_valid(chan1_cond_valid),
      .current_setpoint(current_setpoint),
      .current_setpoint_valid(current_setpoint_valid),
      .speed_setpoint(speed_setpoint),
      .speed_setpoint_valid(speed_setpoint_valid));
   sample_source src_u (.clock(clock), .chan1_sample(chan1_sample),
      .chan1_valid(chan1_valid), .chan2_sample(chan2_sample),
      .chan2_valid(chan2_valid));
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ======================================================
   // Helpers
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One parameter access; wr low means read
   task automatic acc(input logic wr, input logic [15:0] a, d, exp,
                      input logic err);
      @(posedge clock);
      param_addr    <= a;
      param_wr_data <= d;
      param_wr_en   <= wr;
      param_rd_en   <= !wr;
      @(posedge clock);
      param_wr_en   <= 1'b0;
      param_rd_en   <= 1'b0;
      #1;
      chk("error", {15'h0, param_error}, {15'h0, err});
      chk("rd_valid", {15'h0, param_rd_valid}, {15'h0, !wr});
      if (!wr)
         chk("rd_data", param_rd_data, exp);
   endtask
   // One channel one sample with its expected results
   task automatic run(input logic m, input logic [15:0] s, c, ci, cn);
      @(posedge clock);
      speed_mode <= m;
      src_u.send1(s);
      #1;
      chk("cond", chan1_conditioned, c);
      chk("cond_valid", {15'h0, chan1_cond_valid}, 16'h0001);
      @(posedge clock);
      #1;
      chk("current", current_setpoint, ci);
      chk("speed", speed_setpoint, cn);
      chk("valids", {14'h0, current_setpoint_valid, speed_setpoint_valid},
          {14'h0, !m, m});
      acc(1'b0, 16'h0902, 16'h0, c, 1'b0);
   endtask
   task automatic test_done;
      $display("Checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ======================================================
   // Main sequence
   initial
   begin
      {rst_n, speed_mode, param_wr_en, param_rd_en} = 4'h0;
      {param_addr, param_wr_data} = 32'h0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      acc(1'b0, 16'h0912, 16'h0, 16'h0000, 1'b0);
      acc(1'b0, 16'h0916, 16'h0, 16'h0000, 1'b0);
      acc(1'b0, 16'h2006, 16'h0, 16'h012C, 1'b0);
      acc(1'b0, 16'h2106, 16'h0, 16'h0BB8, 1'b0);
      acc(1'b0, 16'h1204, 16'h0, 16'h3390, 1'b0);
      acc(1'b0, 16'h0902, 16'h0, 16'h0000, 1'b0);
      acc(1'b0, 16'h0100, 16'h0, 16'h0000, 1'b1);
      acc(1'b1, 16'h0902, 16'h1234, 16'h0, 1'b1);
      acc(1'b1, 16'h090A, 16'h1234, 16'h0, 1'b1);
      for (int i = 0; i < 5; i++)
      begin
         acc(1'b1, 16'h0916, tbl[i][0], 16'h0, 1'b0);
         acc(1'b1, 16'h0912, tbl[i][1], 16'h0, 1'b0);
         acc(1'b1, 16'h2006, tbl[i][2], 16'h0, 1'b0);
         acc(1'b1, 16'h2106, tbl[i][3], 16'h0, 1'b0);
         run(tbl[i][4][0], tbl[i][5], tbl[i][6], tbl[i][7], tbl[i][8]);
      end
      acc(1'b0, 16'h0916, 16'h0, 16'h1388, 1'b0);
      src_u.send2(16'hD120);
      acc(1'b0, 16'h090A, 16'h0, 16'hD8F0, 1'b0);
      // Band edge: corrected -1000 with a band of 1000 reads as zero
      acc(1'b1, 16'h0912, 16'h0FFF, 16'h0, 1'b0);
      acc(1'b0, 16'h0912, 16'h0, 16'h03E8, 1'b0);
      run(1'b0, 16'hE890, 16'h0000, 16'h0000, 16'h0000);
      // Speed limit write is clamped, then lowered to 1000 rpm
      acc(1'b1, 16'h1204, 16'hFFFF, 16'h0, 1'b0);
      acc(1'b0, 16'h1204, 16'h0, 16'h3390, 1'b0);
      acc(1'b1, 16'h1204, 16'h03E8, 16'h0, 1'b0);
      run(1'b1, 16'hD120, 16'hEC78, 16'h3A98, 16'hFC18);
      // Reset in mid-run brings every parameter back to its default
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      acc(1'b0, 16'h0916, 16'h0, 16'h0000, 1'b0);
      acc(1'b0, 16'h0912, 16'h0, 16'h0000, 1'b0);
      acc(1'b0, 16'h2006, 16'h0, 16'h012C, 1'b0);
      acc(1'b0, 16'h2106, 16'h0, 16'h0BB8, 1'b0);
      acc(1'b0, 16'h1204, 16'h0, 16'h3390, 1'b0);
      acc(1'b0, 16'h0902, 16'h0, 16'h0000, 1'b0);
      acc(1'b0, 16'h090A, 16'h0, 16'h0000, 1'b0);
      test_done;
   end

   // Watchdog against a hang
   initial
   begin
      repeat (4000) @(posedge clock);
      mismatches++;
      test_done;
   end
endmodule // tb_top
